// File: design/tpl_pkg.sv
// package: register map, control word fields and shared types of the probe latch
package tpl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_POS = 8'h0c;
  // control word field positions
  localparam int BIT_ENABLE = 8;
  localparam int BIT_MODE = 9;
  localparam int BIT_SOURCE = 10;
  localparam int BIT_RISE = 12;
  localparam int BIT_FALL = 13;
  localparam logic [15:0] CTRL_USED = 16'h3700;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // status bit positions
  localparam int ST_CAPTURE = 0;
  localparam int ST_OVERRUN = 1;
  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic fallEn;
    logic riseEn;
    logic source;
    logic contMode;
    logic enable;
  } tpl_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } tpl_edge_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ARMED = 3'b010,
    ST_DONE = 3'b100
  } tpl_state_t;
endpackage

// File: design/tpl_edge_detect.sv
// edge detector: two-flop synchroniser on a pin plus rise/fall pulses
module tpl_edge_detect (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // asynchronous pin
  input wire logic pinIn,
  // one-cycle edge pulses
  output tpl_pkg::tpl_edge_t edges
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign edges.rise = sync2_r & ~prev_r;
  assign edges.fall = ~sync2_r & prev_r;
endmodule

// File: design/tpl_probe_latch.sv
// second touch-probe position latch with ahb-lite register access
// How it works
// - ctrl bit 9: 0 latches first event only, 1 latches every event
// - ctrl bit 10: 0 digital input line, 1 encoder index pulse
// - ctrl bit 12 enables capture on rising edges of the trigger
// - ctrl bit 13 enables capture on falling edges of the trigger
// - settings live in bits 8 to 13; bits 11, 14, 15 have no effect
// - ctrl bit 8 switches the probe on; 0 switches it off
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
module tpl_probe_latch #(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // trigger pins and position
  input wire logic digital_input_line,
  input wire logic encoderIndex,
  input wire logic [POS_W-1:0] position,
  // results
  output logic [POS_W-1:0] latchedPos,
  output logic captureStb,
  output logic irq
);
  tpl_pkg::tpl_edge_t diEdges;
  tpl_pkg::tpl_edge_t ixEdges;
  tpl_pkg::tpl_edge_t selEdges;
  tpl_pkg::tpl_ctrl_t ctrl;
  tpl_pkg::tpl_state_t state_r;
  tpl_pkg::tpl_state_t state_nxt;
  logic [15:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [POS_W-1:0] latchedPos_r;
  logic captureStb_r;
  logic dWrite_r;
  logic dRead_r;
  logic [7:0] dAddr_r;
  logic [31:0] hrdata_r;

  tpl_edge_detect u_di (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(digital_input_line),
    .edges(diEdges)
  );

  tpl_edge_detect u_ix (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(encoderIndex),
    .edges(ixEdges)
  );

  // control word decode
  assign ctrl.enable = ctrl_r[tpl_pkg::BIT_ENABLE];
  assign ctrl.contMode = ctrl_r[tpl_pkg::BIT_MODE];
  assign ctrl.source = ctrl_r[tpl_pkg::BIT_SOURCE];
  assign ctrl.riseEn = ctrl_r[tpl_pkg::BIT_RISE];
  assign ctrl.fallEn = ctrl_r[tpl_pkg::BIT_FALL];

  wire tpl_pkg::tpl_edge_t srcEdges = ctrl.source ? ixEdges : diEdges;
  assign selEdges = srcEdges;
  wire trigHit = (selEdges.rise & ctrl.riseEn) | (selEdges.fall & ctrl.fallEn);
  wire armed = (state_r == tpl_pkg::ST_ARMED);
  wire doCapture = armed & ctrl.enable & trigHit;
  wire missed = ctrl.enable & ~ctrl.contMode & (state_r == tpl_pkg::ST_DONE) & trigHit;

  // bus decode
  wire addrPhase = hsel & hready & (htrans == tpl_pkg::HTRANS_NONSEQ);
  wire wrCtrl = dWrite_r & (dAddr_r == tpl_pkg::OFS_CTRL);
  wire wrMask = dWrite_r & (dAddr_r == tpl_pkg::OFS_MASK);
  wire rdStat = dRead_r & (dAddr_r == tpl_pkg::OFS_STAT);
  wire [15:0] ctrlMasked = hwdata[15:0] & tpl_pkg::CTRL_USED;
  wire [1:0] events = {missed, doCapture};
  wire [31:0] rdMux =
    (haddr == tpl_pkg::OFS_CTRL) ? {16'h0000, ctrl_r} :
    (haddr == tpl_pkg::OFS_STAT) ? {30'h0, stat_r} :
    (haddr == tpl_pkg::OFS_MASK) ? {30'h0, mask_r} :
    (haddr == tpl_pkg::OFS_POS) ? 32'(latchedPos_r) : 32'h00000000;

  // probe state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tpl_pkg::ST_OFF: begin
        if (ctrl.enable) begin
          state_nxt = tpl_pkg::ST_ARMED;
        end
      end
      tpl_pkg::ST_ARMED: begin
        if (!ctrl.enable) begin
          state_nxt = tpl_pkg::ST_OFF;
        end else if (trigHit && !ctrl.contMode) begin
          state_nxt = tpl_pkg::ST_DONE;
        end
      end
      tpl_pkg::ST_DONE: begin
        if (!ctrl.enable) begin
          state_nxt = tpl_pkg::ST_OFF;
        end else if (ctrl.contMode) begin
          state_nxt = tpl_pkg::ST_ARMED;
        end
      end
      default: begin
        state_nxt = tpl_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= tpl_pkg::ST_OFF;
      latchedPos_r <= '0;
      captureStb_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      captureStb_r <= doCapture;
      if (doCapture) begin
        latchedPos_r <= position;
      end
    end
  end

  // bus data phase and registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dWrite_r <= 1'b0;
      dRead_r <= 1'b0;
      dAddr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      dWrite_r <= addrPhase & hwrite;
      dRead_r <= addrPhase & ~hwrite;
      dAddr_r <= haddr;
      if (addrPhase && !hwrite) begin
        hrdata_r <= rdMux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= tpl_pkg::CTRL_RESET;
      mask_r <= tpl_pkg::MASK_RESET;
      stat_r <= tpl_pkg::STAT_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= ctrlMasked;
      end
      if (wrMask) begin
        mask_r <= hwdata[1:0];
      end
      // a new event wins over the read clear
      stat_r <= (rdStat ? 2'h0 : stat_r) | events;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign latchedPos = latchedPos_r;
  assign captureStb = captureStb_r;
  assign irq = |(stat_r & mask_r);

  // checks
  property p_single_stop;
    @(posedge sys_clk) disable iff (!resetn)
      (captureStb && !$past(ctrl.contMode) && ctrl.enable && !ctrl.contMode && !wrCtrl)
      |-> !doCapture;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single mode captured twice");

  property p_source_sel;
    @(posedge sys_clk) disable iff (!resetn)
      (armed && ctrl.riseEn && !ctrl.fallEn && !ctrl.source && diEdges.rise) |-> doCapture;
  endproperty
  a_source_sel: assert property (p_source_sel) else $error("input line edge missed");

  property p_index_sel;
    @(posedge sys_clk) disable iff (!resetn)
      (ctrl.source && !ixEdges.rise && !ixEdges.fall) |-> !doCapture;
  endproperty
  a_index_sel: assert property (p_index_sel) else $error("capture without index edge");

  property p_rise_gate;
    @(posedge sys_clk) disable iff (!resetn)
      (!ctrl.riseEn && selEdges.rise) |-> !doCapture;
  endproperty
  a_rise_gate: assert property (p_rise_gate) else $error("rising capture while disabled");

  property p_fall_gate;
    @(posedge sys_clk) disable iff (!resetn)
      (!ctrl.fallEn && selEdges.fall) |-> !doCapture;
  endproperty
  a_fall_gate: assert property (p_fall_gate) else $error("falling capture while disabled");

  property p_unused_bits;
    @(posedge sys_clk) disable iff (!resetn)
      1'b1 |-> ((ctrl_r & ~tpl_pkg::CTRL_USED) == 16'h0000);
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused control bit set");

  property p_off;
    @(posedge sys_clk) disable iff (!resetn)
      !ctrl.enable |=> !captureStb;
  endproperty
  a_off: assert property (p_off) else $error("capture while probe off");

  property p_latch_value;
    @(posedge sys_clk) disable iff (!resetn)
      doCapture |=> (captureStb && latchedPos == $past(position) && stat_r[tpl_pkg::ST_CAPTURE]);
  endproperty
  a_latch_value: assert property (p_latch_value) else $error("latched value wrong");

  property p_no_edges;
    @(posedge sys_clk) disable iff (!resetn)
      (!ctrl.riseEn && !ctrl.fallEn) |-> !doCapture;
  endproperty
  a_no_edges: assert property (p_no_edges) else $error("capture with no edge enabled");

  c_single: cover property (@(posedge sys_clk) disable iff (!resetn)
    doCapture && !ctrl.contMode);
  c_cont: cover property (@(posedge sys_clk) disable iff (!resetn)
    doCapture && ctrl.contMode ##[1:50] doCapture);
  c_index: cover property (@(posedge sys_clk) disable iff (!resetn)
    doCapture && ctrl.source);
  c_irq: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
endmodule

// File: verif/tpl_trig_model.sv
// trigger pin model: digital input line and encoder index pulse
module tpl_trig_model (
  // clock
  input wire logic sys_clk,
  // trigger pins
  output logic digital_input_line,
  output logic encoderIndex
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    digital_input_line = 1'b0;
    encoderIndex = 1'b0;
  end
  // flip one pin after an edge, then hold it well past the two-cycle minimum
  task automatic flip(input logic src);
    if (src) begin
      encoderIndex <= ~encoderIndex;
    end else begin
      digital_input_line <= ~digital_input_line;
    end
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// File: verif/tpl_probe_latch_test.sv
// testbench: register access, trigger selection, edge gating and latch modes
module tpl_probe_latch_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] position = 32'h0;
  logic [31:0] hrdata, latchedPos, rd, cfg;
  logic hreadyout, hresp, captureStb, irq, digitalIn, encIdx, src;
  int bad_count = 0;
  int cmp_count = 0;
  int strobes = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (captureStb === 1'b1) strobes <= strobes + 1;
  tpl_trig_model tpl_trig_model_i (.sys_clk(sys_clk), .digital_input_line(digitalIn),
    .encoderIndex(encIdx));
  tpl_probe_latch #(.POS_W(32)) tpl_probe_latch_i (.sys_clk(sys_clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .digital_input_line(digitalIn), .encoderIndex(encIdx),
    .position(position), .latchedPos(latchedPos), .captureStb(captureStb), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= tpl_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= tpl_pkg::HSIZE_WORD;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rchk(tpl_pkg::OFS_CTRL, 32'h0);
    rchk(tpl_pkg::OFS_STAT, 32'h0);
    rchk(tpl_pkg::OFS_MASK, 32'h0);
    rchk(8'h10, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk(latchedPos, 32'h0);
    bus(1'b1, tpl_pkg::OFS_CTRL, 32'hffff);
    rchk(tpl_pkg::OFS_CTRL, 32'h3700);
    $display("test reset_and_map done");
    // continuous mode, unused bits 11, 14, 15 set on purpose
    for (int i = 0; i < 8; i++) begin
      src = i[0];
      cfg = 32'hcb00;
      cfg = cfg | (32'(src) << 10) | (32'(i[1]) << 12) | (32'(i[2]) << 13);
      bus(1'b1, tpl_pkg::OFS_CTRL, cfg);
      position <= 32'h1000 + i;
      tpl_trig_model_i.flip(~src);
      tpl_trig_model_i.flip(~src);
      rchk(tpl_pkg::OFS_STAT, 32'h0);
      tpl_trig_model_i.flip(src);
      rchk(tpl_pkg::OFS_STAT, 32'(i[1]));
      if (i[1]) begin
        rchk(tpl_pkg::OFS_POS, 32'h1000 + i);
        chk(latchedPos, 32'h1000 + i);
      end
      tpl_trig_model_i.flip(src);
      rchk(tpl_pkg::OFS_STAT, 32'(i[2]));
    end
    chk(strobes, 32'h8);
    $display("test edges_and_sources done");
    bus(1'b1, tpl_pkg::OFS_CTRL, 32'h3200);
    tpl_trig_model_i.flip(1'b0);
    tpl_trig_model_i.flip(1'b0);
    rchk(tpl_pkg::OFS_STAT, 32'h0);
    $display("test disabled done");
    bus(1'b1, tpl_pkg::OFS_MASK, 32'h1);
    bus(1'b1, tpl_pkg::OFS_CTRL, 32'h3100);
    position <= 32'hab;
    tpl_trig_model_i.flip(1'b0);
    chk({31'h0, irq}, 32'h1);
    rchk(tpl_pkg::OFS_STAT, 32'h1);
    // the read clear lands at the edge that ends the read
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    position <= 32'hcd;
    tpl_trig_model_i.flip(1'b0);
    chk({31'h0, irq}, 32'h0);
    chk(latchedPos, 32'hab);
    rchk(tpl_pkg::OFS_STAT, 32'h2);
    rchk(tpl_pkg::OFS_POS, 32'hab);
    $display("test single_and_irq done");
    stop_test();
  end
endmodule
